// >>> rtl/ppc_drv_reg.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// one output driver register with nibble decode
// ****************************************************************
module ppc_drv_reg
  import ppc_pkg::*;
#(
  parameter ppc_idx_t IDX = 16'h0000,
  parameter int       NIB = 2
) (
  input  wire logic           clk_in,
  input  wire logic           rstn_in,
  ppc_wr_if.dst               wr,
  output logic [15:0]         value_out,
  output logic [NIB-1:0]      slow_edge_out,
  output logic [NIB-1:0]      dyn_drive_out,
  output logic [NIB-1:0]      low_drive_out
);
  // fields above the last nibble do not exist and read zero
  localparam logic [15:0] WMASK = 16'((32'd1 << (NIB_W * NIB)) - 32'd1);

  logic [15:0]    value_ff;
  logic [15:0]    nxt_value;
  logic [NIB-1:0] slow_ff;
  logic [NIB-1:0] dyn_ff;
  logic [NIB-1:0] low_ff;

  // byte lane merge
  always_comb begin
    nxt_value = value_ff;
    if (wr.wr_en && (wr.wr_idx == IDX)) begin
      if (wr.wr_be[0]) nxt_value[7:0] = wr.wr_data[7:0];
      if (wr.wr_be[1]) nxt_value[15:8] = wr.wr_data[15:8];
    end
    nxt_value = nxt_value & WMASK;
  end

  // stored fields, all zero after reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) value_ff <= DRV_RST;
    else value_ff <= nxt_value;
  end

  // decode from the next value so pads follow the register without lag
  for (genvar n = 0; n < NIB; n++) begin : g_nib
    always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
        slow_ff[n] <= 1'b0;
        dyn_ff[n]  <= 1'b0;
        low_ff[n]  <= 1'b0;
      end else begin
        // reserved codes fall back to fast edge and full strength
        slow_ff[n] <= nxt_value[n*NIB_W+EDGE_LSB +: 2] == EDGE_SLOW;
        dyn_ff[n]  <= nxt_value[n*NIB_W+DRIVE_LSB +: 2] == DRIVE_DYN;
        low_ff[n]  <= nxt_value[n*NIB_W+DRIVE_LSB +: 2] == DRIVE_LOW;
      end
    end
  end

  assign value_out     = value_ff;
  assign slow_edge_out = slow_ff;
  assign dyn_drive_out = dyn_ff;
  assign low_drive_out = low_ff;
endmodule
`default_nettype wire

// >>> rtl/ppc_od_reg.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// one open drain select register
// ****************************************************************
module ppc_od_reg
  import ppc_pkg::*;
#(
  parameter ppc_idx_t    IDX  = 16'h0000,
  parameter int          W    = 8,
  parameter logic [15:0] MASK = 16'h00ff
) (
  input  wire logic   clk_in,
  input  wire logic   rstn_in,
  ppc_wr_if.dst       wr,
  output logic [15:0] value_out,
  output logic [W-1:0] od_out
);
  logic [15:0] value_ff;
  logic [15:0] nxt_value;

  // byte lane merge, missing lines masked off
  always_comb begin
    nxt_value = value_ff;
    if (wr.wr_en && (wr.wr_idx == IDX)) begin
      if (wr.wr_be[0]) nxt_value[7:0] = wr.wr_data[7:0];
      if (wr.wr_be[1]) nxt_value[15:8] = wr.wr_data[15:8];
    end
    nxt_value = nxt_value & MASK;
  end

  // one bit per line, clear selects push-pull
  always_ff @(posedge clk_in) begin
    if (!rstn_in) value_ff <= OD_RST;
    else value_ff <= nxt_value;
  end

  assign value_out = value_ff;
  assign od_out    = value_ff[W-1:0];
endmodule
`default_nettype wire

// >>> rtl/ppc_pkg.sv
// ****************************************************************
// pad configuration constants
// ****************************************************************
package ppc_pkg;

  // bus geometry
  localparam int AXI_AW    = 18;
  localparam int AXI_DW    = 32;
  localparam int REG_W     = 16;

  // register index, byte address is four times this
  typedef logic [15:0] ppc_idx_t;

  // output driver registers, one per port half or port
  localparam int       N_DRV            = 10;
  localparam ppc_idx_t DRV_IDX [N_DRV]  = '{16'hf080, 16'hf082, 16'hf084, 16'hf086, 16'hf088,
                                            16'hf08a, 16'hf08c, 16'hf08e, 16'hf090, 16'hf092};
  localparam int       DRV_NIB [N_DRV]  = '{2, 2, 2, 2, 4, 4, 2, 2, 2, 2};
  localparam int       DRV_NBASE[N_DRV] = '{0, 2, 4, 6, 8, 12, 16, 18, 20, 22};
  localparam int       N_NIB            = 24;
  localparam logic [15:0] DRV_RST       = 16'h0000;

  // nibble field layout
  localparam int NIB_W     = 4;
  localparam int EDGE_LSB  = 0;
  localparam int DRIVE_LSB = 2;

  // field codes
  localparam logic [1:0] EDGE_FAST  = 2'b00;
  localparam logic [1:0] EDGE_SLOW  = 2'b01;
  localparam logic [1:0] DRIVE_FULL = 2'b00;
  localparam logic [1:0] DRIVE_DYN  = 2'b01;
  localparam logic [1:0] DRIVE_LOW  = 2'b10;

  // open drain select registers, ports 2 3 4 6 7 8, extended space
  localparam int          N_OD            = 6;
  localparam int          N_OD_PIN        = 64;
  localparam ppc_idx_t    OD_IDX [N_OD]   = '{16'hf1c8, 16'hf1ca, 16'hf1cc, 16'hf1ce, 16'hf1d0, 16'hf1d2};
  localparam int          OD_W   [N_OD]   = '{16, 16, 8, 8, 8, 8};
  localparam int          OD_BASE[N_OD]   = '{0, 16, 32, 40, 48, 56};
  localparam logic [15:0] OD_MASK[N_OD]   = '{16'hffff, 16'hbfff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff};
  localparam logic [15:0] OD_RST          = 16'h0000;

  // input threshold register, bytes p2l p2h p3l p3h p4 - p7 p8
  localparam ppc_idx_t    THR_IDX         = 16'hf1c4;
  localparam logic [7:0]  THR_MASK        = 8'hdf;
  localparam logic [7:0]  THR_RST         = 8'h00;
  localparam int          N_THR_PIN       = 56;
  localparam int          THR_POS[7]      = '{0, 1, 2, 3, 4, 6, 7};
  localparam logic [55:0] THR_PIN_MASK    = 56'hffffff_bfff_ffff;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// >>> rtl/ppc_top.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Open drain bit clear, the reset state, gives a push-pull driver.
// - Open drain bit set makes the line drive low only.
// - Open drain control exists only for ports 2, 3, 4, 6, 7, 8.
// - Every open drain capable line has its own select bit.
// - Open drain select registers live in the extended register space.
// - Threshold select per byte: one bit for ports 4, 7, 8; two for 2, 3.
// - Low byte select 0 gives TTL on pins 7..0, 1 gives hysteresis.
// - High byte select 0 gives TTL on pins 15..8, 1 gives hysteresis.
// - Direction and driver mode ignore the selected input threshold.
// - Edge rate chosen per nibble of pins by a two bit field.
// - Drive strength chosen per same nibble by its own two bit field.
// - Edge code 00 fast, 01 slow, 10 and 11 reserved.
// - Drive code 00 full, 01 dynamic, 10 reduced, 11 reserved.
// - Output control registers of 8-bit ports read zero in bits 15..8.
// - Nibble 0 drives pins 3..0 upward; port 3 top nibble has 15, 13, 12.
module ppc_top
  import ppc_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rstn_in,
  // write address and data
  input  wire logic [AXI_AW-1:0]    s_axi_awaddr_in,
  input  wire logic                 s_axi_awvalid_in,
  output logic                      s_axi_awready_out,
  input  wire logic [AXI_DW-1:0]    s_axi_wdata_in,
  input  wire logic [3:0]           s_axi_wstrb_in,
  input  wire logic                 s_axi_wvalid_in,
  output logic                      s_axi_wready_out,
  // write response
  output logic [1:0]                s_axi_bresp_out,
  output logic                      s_axi_bvalid_out,
  input  wire logic                 s_axi_bready_in,
  // read channels
  input  wire logic [AXI_AW-1:0]    s_axi_araddr_in,
  input  wire logic                 s_axi_arvalid_in,
  output logic                      s_axi_arready_out,
  output logic [AXI_DW-1:0]         s_axi_rdata_out,
  output logic [1:0]                s_axi_rresp_out,
  output logic                      s_axi_rvalid_out,
  input  wire logic                 s_axi_rready_in,
  // pad controls, all from flops
  output logic [N_OD_PIN-1:0]       open_drain_out,
  output logic [N_THR_PIN-1:0]      hyst_en_out,
  output logic [N_NIB-1:0]          slow_edge_out,
  output logic [N_NIB-1:0]          dyn_drive_out,
  output logic [N_NIB-1:0]          low_drive_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  // shared write carrier
  ppc_wr_if wr_bus ();

  // bus channel state
  logic              awready_ff;
  logic              wready_ff;
  logic              aw_got_ff;
  logic              w_got_ff;
  logic [AXI_AW-1:0] aw_addr_ff;
  logic [15:0]       w_data_ff;
  logic [1:0]        w_be_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [AXI_DW-1:0] rdata_ff;
  logic [1:0]        rresp_ff;

  // registered write strobe
  logic              wr_en_ff;
  ppc_idx_t          wr_idx_ff;
  logic [15:0]       wr_data_ff;
  logic [1:0]        wr_be_ff;

  // decode helpers
  logic              aw_take;
  logic              w_take;
  logic              wr_fire;
  logic              wr_hit;
  ppc_idx_t          aw_idx;
  logic              rd_hit;
  logic [15:0]       rd_val;
  ppc_idx_t          ar_idx;

  // threshold select
  logic [7:0]        thr_ff;
  logic [7:0]        nxt_thr;
  logic [N_THR_PIN-1:0] hyst_ff;

  // read back views
  logic [15:0]       drv_val [N_DRV];
  logic [15:0]       od_val  [N_OD];

  // ****************************************************************
  // write address and data channels
  // ****************************************************************

  // both channels may arrive in either order; each is held once taken
  // low ready flags keep one write in flight
  assign aw_take = s_axi_awvalid_in && awready_ff;
  assign w_take  = s_axi_wvalid_in && wready_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign aw_idx  = aw_addr_ff[17:2];

  // address channel capture
  // whole address kept to refuse unaligned
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      awready_ff <= 1'b1;
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= '0;
    end else if (aw_take) begin
      awready_ff <= 1'b0;
      aw_got_ff  <= 1'b1;
      aw_addr_ff <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_got_ff <= 1'b0;
    end else if (bvalid_ff && s_axi_bready_in) begin
      awready_ff <= 1'b1; // reopen only after the response is gone
    end
  end

  // data channel capture, only the low half-word is backed by storage
  // strobes of lanes 3 and 2 are dropped
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      wready_ff <= 1'b1;
      w_got_ff  <= 1'b0;
      w_data_ff <= '0;
      w_be_ff   <= '0;
    end else if (w_take) begin
      wready_ff <= 1'b0;
      w_got_ff  <= 1'b1;
      w_data_ff <= s_axi_wdata_in[15:0];
      w_be_ff   <= s_axi_wstrb_in[1:0];
    end else if (wr_fire) begin
      w_got_ff <= 1'b0;
    end else if (bvalid_ff && s_axi_bready_in) begin
      wready_ff <= 1'b1;
    end
  end

  // ****************************************************************
  // write decode and response
  // ****************************************************************

  // mapped only at an aligned word of a known index
  // this copy picks the response code and gates the write strobe
  always_comb begin
    wr_hit = 1'b0;
    if (aw_addr_ff[1:0] == 2'b00) begin
      if (aw_idx == THR_IDX) wr_hit = 1'b1;
      for (int i = 0; i < N_DRV; i++) begin
        if (aw_idx == DRV_IDX[i]) wr_hit = 1'b1;
      end
      for (int i = 0; i < N_OD; i++) begin
        if (aw_idx == OD_IDX[i]) wr_hit = 1'b1;
      end
    end
  end

  // one-cycle strobe toward the register holders
  // a cycle of latency keeps decode off the bus path
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      wr_en_ff   <= 1'b0;
      wr_idx_ff  <= '0;
      wr_data_ff <= '0;
      wr_be_ff   <= '0;
    end else begin
      wr_en_ff   <= wr_fire && wr_hit; // unmapped writes change nothing
      wr_idx_ff  <= aw_idx;
      wr_data_ff <= w_data_ff;
      wr_be_ff   <= w_be_ff;
    end
  end

  assign wr_bus.wr_en   = wr_en_ff;
  assign wr_bus.wr_idx  = wr_idx_ff;
  assign wr_bus.wr_data = wr_data_ff;
  assign wr_bus.wr_be   = wr_be_ff;

  // write response held until the master takes it
  // code fixed when the write fires
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  // low address bits must be zero for a hit
  assign ar_idx = s_axi_araddr_in[17:2];

  // read mux over all register holders
  // a miss reads zero with an error code
  always_comb begin
    rd_hit = 1'b0;
    rd_val = '0;
    if (s_axi_araddr_in[1:0] == 2'b00) begin
      if (ar_idx == THR_IDX) begin
        rd_hit = 1'b1;
        rd_val = {8'h00, thr_ff};
      end
      for (int i = 0; i < N_DRV; i++) begin
        if (ar_idx == DRV_IDX[i]) begin
          rd_hit = 1'b1;
          rd_val = drv_val[i];
        end
      end
      for (int i = 0; i < N_OD; i++) begin
        if (ar_idx == OD_IDX[i]) begin
          rd_hit = 1'b1;
          rd_val = od_val[i];
        end
      end
    end
  end

  // data sampled at the address handshake, held until taken
  // arready low while rvalid stands: one read
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else if (s_axi_arvalid_in && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= {16'h0000, rd_val};
      rresp_ff   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready_in) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  // ****************************************************************
  // input threshold select
  // ****************************************************************

  // bit 5 has no port behind it and stays zero
  // only the low lane holds select bits
  always_comb begin
    nxt_thr = thr_ff;
    if (wr_en_ff && (wr_idx_ff == THR_IDX) && wr_be_ff[0]) begin
      nxt_thr = wr_data_ff[7:0];
    end
    nxt_thr = nxt_thr & THR_MASK;
  end

  // all TTL after reset
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) thr_ff <= THR_RST;
    else thr_ff <= nxt_thr;
  end

  // fan each byte select out to its eight pads, one set means hysteresis
  // next value decode: no lag behind the register
  // port 3 pin 14 does not exist, held low
  for (genvar p = 0; p < N_THR_PIN; p++) begin : g_thr
    always_ff @(posedge mclk_in) begin
      if (!rstn_in) hyst_ff[p] <= 1'b0;
      else hyst_ff[p] <= nxt_thr[THR_POS[p/8]] & THR_PIN_MASK[p];
    end
  end

  // hysteresis enables to the pads
  assign hyst_en_out = hyst_ff;

  // ****************************************************************
  // output driver registers
  // ****************************************************************

  // nibble n of each register controls pins 4n+3..4n of its port
  // one strobe carrier serves the driver and open drain holders
  for (genvar i = 0; i < N_DRV; i++) begin : g_drv
    ppc_drv_reg #(
      .IDX (DRV_IDX[i]),
      .NIB (DRV_NIB[i])
    ) ppc_drv_reg_inst (
      .clk_in        (mclk_in),
      .rstn_in       (rstn_in),
      .wr            (wr_bus.dst),
      .value_out     (drv_val[i]),
      .slow_edge_out (slow_edge_out[DRV_NBASE[i] +: DRV_NIB[i]]),
      .dyn_drive_out (dyn_drive_out[DRV_NBASE[i] +: DRV_NIB[i]]),
      .low_drive_out (low_drive_out[DRV_NBASE[i] +: DRV_NIB[i]])
    );
  end

  // ****************************************************************
  // open drain select registers
  // ****************************************************************

  // driver mode bits never look at the threshold bits, by construction
  // masks keep absent lines at push-pull
  for (genvar i = 0; i < N_OD; i++) begin : g_od
    ppc_od_reg #(
      .IDX  (OD_IDX[i]),
      .W    (OD_W[i]),
      .MASK (OD_MASK[i])
    ) ppc_od_reg_inst (
      .clk_in    (mclk_in),
      .rstn_in   (rstn_in),
      .wr        (wr_bus.dst),
      .value_out (od_val[i]),
      .od_out    (open_drain_out[OD_BASE[i] +: OD_W[i]])
    );
  end

  // ****************************************************************
  // bus outputs
  // ****************************************************************

  // bus outputs straight from flops
  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out  = wready_ff;
  assign s_axi_bvalid_out  = bvalid_ff;
  assign s_axi_bresp_out   = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out  = rvalid_ff;
  assign s_axi_rdata_out   = rdata_ff;
  assign s_axi_rresp_out   = rresp_ff;

endmodule
`default_nettype wire

// >>> rtl/ppc_wr_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// register write strobe carrier
// ****************************************************************
interface ppc_wr_if;
  import ppc_pkg::*;
  logic        wr_en;
  ppc_idx_t    wr_idx;
  logic [15:0] wr_data;
  logic [1:0]  wr_be;
  modport src (output wr_en, output wr_idx, output wr_data, output wr_be);
  modport dst (input wr_en, input wr_idx, input wr_data, input wr_be);
endinterface
`default_nettype wire

// >>> tb/ppc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port level checks for the pad configuration block
// ****************************************************************
module ppc_checker
  import ppc_pkg::*;
(
  input wire logic                 mclk_in,
  input wire logic                 rstn_in,
  input wire logic                 s_axi_awvalid_in,
  input wire logic                 s_axi_awready_out,
  input wire logic                 s_axi_wvalid_in,
  input wire logic                 s_axi_wready_out,
  input wire logic                 s_axi_bvalid_out,
  input wire logic                 s_axi_bready_in,
  input wire logic                 s_axi_arvalid_in,
  input wire logic                 s_axi_arready_out,
  input wire logic                 s_axi_rvalid_out,
  input wire logic [AXI_DW-1:0]    s_axi_rdata_out,
  input wire logic [N_OD_PIN-1:0]  open_drain_out,
  input wire logic [N_THR_PIN-1:0] hyst_en_out,
  input wire logic [N_NIB-1:0]     slow_edge_out,
  input wire logic [N_NIB-1:0]     dyn_drive_out,
  input wire logic [N_NIB-1:0]     low_drive_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  // reset clears answers and every pad setting
  a_reset_clear: assert property (disable iff (1'b0) !rstn_in |=>
    !s_axi_bvalid_out && !s_axi_rvalid_out && open_drain_out == '0 && hyst_en_out == '0
    && slow_edge_out == '0 && dyn_drive_out == '0 && low_drive_out == '0)
    else $error("pads or answers not cleared by reset");
  a_write_resp: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##2 s_axi_bvalid_out) else $error("write answer late");
  a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write answer dropped early");
  a_aw_blocked: assert property (s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out [*2])
    else $error("second write address taken in flight");
  a_read_resp: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
    s_axi_rvalid_out && !s_axi_arready_out && s_axi_rdata_out[31:16] == 16'h0000)
    else $error("read answer wrong");
  // pads move only on the edge after a write answer is raised
  a_pad_cause: assert property ($past(rstn_in) && !$stable({open_drain_out, hyst_en_out, slow_edge_out,
    dyn_drive_out, low_drive_out}) |-> $past(s_axi_bvalid_out)) else $error("pads changed without write");
  a_thr_isolation: assert property ($past(rstn_in) && !$stable(hyst_en_out) |->
    $stable(open_drain_out) && $stable(slow_edge_out) && $stable(low_drive_out))
    else $error("threshold write disturbed driver mode");
  a_drive_excl: assert property ((dyn_drive_out & low_drive_out) == '0)
    else $error("drive decode not exclusive");
  a_port3_gap: assert property (!open_drain_out[30] && !hyst_en_out[30])
    else $error("missing port 3 line driven");
endmodule

bind ppc_top ppc_checker ppc_checker_inst (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rdata_out(s_axi_rdata_out),
  .open_drain_out(open_drain_out), .hyst_en_out(hyst_en_out), .slow_edge_out(slow_edge_out),
  .dyn_drive_out(dyn_drive_out), .low_drive_out(low_drive_out));
`default_nettype wire

// >>> tb/tb_ppc_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// register level bench
// ****************************************************************
module tb_ppc_top;
  import ppc_pkg::*;
  logic                 mclk_in = 1'b0;
  logic                 rstn_in = 1'b0;
  logic [AXI_AW-1:0]    awaddr  = '0;
  logic                 awvalid = 1'b0;
  logic                 awready;
  logic [AXI_DW-1:0]    wdata   = '0;
  logic [3:0]           wstrb   = '0;
  logic                 wvalid  = 1'b0;
  logic                 wready;
  logic [1:0]           bresp;
  logic                 bvalid;
  logic                 bready  = 1'b0;
  logic [AXI_AW-1:0]    araddr  = '0;
  logic                 arvalid = 1'b0;
  logic                 arready;
  logic [AXI_DW-1:0]    rdata;
  logic [1:0]           rresp;
  logic                 rvalid;
  logic                 rready  = 1'b0;
  logic [N_OD_PIN-1:0]  od_pads;
  logic [N_THR_PIN-1:0] hyst_pads;
  logic [N_NIB-1:0]     slow_pads;
  logic [N_NIB-1:0]     dyn_pads;
  logic [N_NIB-1:0]     low_pads;
  int                   n_fail = 0;
  int                   comparisons = 0;
  logic [63:0]          exp_od;
  logic [31:0]          rd;
  logic [1:0]           rs;

  always #10 mclk_in = ~mclk_in;

  ppc_top ppc_top_inst (
    .mclk_in(mclk_in), .rstn_in(rstn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .open_drain_out(od_pads), .hyst_en_out(hyst_pads), .slow_edge_out(slow_pads),
    .dyn_drive_out(dyn_pads), .low_drive_out(low_pads));

  // ****************************************************************
  // bus tasks and comparison
  // ****************************************************************
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bready raised only once bvalid is seen, so the slave must hold its answer
  task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [3:0] st, input logic [1:0] lo = 2'b00);
    awaddr  <= {idx, lo};
    wdata   <= {16'h0000, d};
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready === 1'b1));
    rs = bresp;
    bready <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic rd_reg(input logic [15:0] idx, input logic [1:0] lo = 2'b00);
    araddr  <= {idx, lo};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic final_report();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_fail++;
    final_report();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (12) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in);
    for (int i = 0; i < N_DRV; i++) begin
      rd_reg(DRV_IDX[i]);
      chk("drv reset", {rs, rd}, 34'h0);
    end
    for (int i = 0; i < N_OD; i++) begin
      rd_reg(OD_IDX[i]);
      chk("od reset", rd, 32'h0);
    end
    chk("od pads reset", od_pads, 64'h0);
    $display("test reset values done");
    // all ones gives reserved codes everywhere
    for (int i = 0; i < N_DRV; i++) begin
      wr(DRV_IDX[i], 16'hffff, 4'hf);
      rd_reg(DRV_IDX[i]);
      chk("drv width", rd, (DRV_NIB[i] == 4) ? 32'hffff : 32'h00ff);
    end
    chk("reserved edge", slow_pads, 24'h0);
    chk("reserved drive", {dyn_pads, low_pads}, 48'h0);
    wr(DRV_IDX[4], 16'he841, 4'h3);
    wr(DRV_IDX[5], 16'h1000, 4'h3);
    chk("wr resp", rs, RESP_OKAY);
    chk("slow nibbles", slow_pads, 24'h008100);
    chk("dyn nibbles", dyn_pads, 24'h000200);
    chk("low nibbles", low_pads, 24'h000400);
    wr(DRV_IDX[4], 16'h0000, 4'h2);
    rd_reg(DRV_IDX[4]);
    chk("high lane only", rd, 32'h0041);
    chk("low cleared", low_pads, 24'h0);
    $display("test driver control done");
    exp_od = '0;
    for (int i = 0; i < N_OD; i++) begin
      wr(OD_IDX[i], 16'hffff, 4'h3);
      rd_reg(OD_IDX[i]);
      chk("od width", rd, {16'h0000, OD_MASK[i]});
      for (int j = 0; j < OD_W[i]; j++) exp_od[OD_BASE[i] + j] = OD_MASK[i][j];
    end
    chk("od pads all", od_pads, exp_od);
    wr(OD_IDX[2], 16'h0004, 4'h1);
    exp_od[39:32] = 8'h04;
    chk("od single line", od_pads, exp_od);
    $display("test open drain done");
    wr(THR_IDX, 16'hffff, 4'h3);
    rd_reg(THR_IDX);
    chk("thr width", rd, 32'h00df);
    chk("hyst all", hyst_pads, THR_PIN_MASK);
    chk("od kept", od_pads, exp_od);
    wr(THR_IDX, 16'h0002, 4'h3);
    chk("hyst p2 high", hyst_pads, 56'h00ff00);
    wr(THR_IDX, 16'h0001, 4'h3);
    chk("hyst p2 low", hyst_pads, 56'h0000ff);
    wr(THR_IDX, 16'h0010, 4'h3);
    chk("hyst p4", hyst_pads, 56'hff_0000_0000);
    wr(THR_IDX, 16'h00ff, 4'h3, 2'b01);
    chk("unaligned wr", rs, RESP_SLVERR);
    chk("unaligned no effect", hyst_pads, 56'hff_0000_0000);
    rd_reg(THR_IDX, 2'b10);
    chk("unaligned rd", {rs, rd}, {RESP_SLVERR, 32'h0});
    $display("test thresholds done");
    wr(16'hf1c6, 16'hffff, 4'h3);
    chk("unmapped wr", rs, RESP_SLVERR);
    chk("unmapped no effect", od_pads, exp_od);
    rd_reg(16'hf094);
    chk("unmapped rd", {rs, rd}, {RESP_SLVERR, 32'h0});
    rstn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in);
    chk("od after reset", od_pads, 64'h0);
    rd_reg(DRV_IDX[5]);
    chk("drv after reset", rd, 32'h0);
    $display("test errors and reset done");
    final_report();
  end
endmodule
`default_nettype wire
